// ===== design/sfsr_params.svh
// Constants of the serial flash status register block
`ifndef SFSR_PARAMS_SVH
`define SFSR_PARAMS_SVH

// ==========================================================
// Command opcodes
`define SFSR_OP_READ_STATUS   8'h05
`define SFSR_OP_WRITE_STAT1   8'h01
`define SFSR_OP_WRITE_STAT2   8'h31
`define SFSR_OP_WRITE_ENABLE  8'h06
`define SFSR_OP_WRITE_DISABLE 8'h04
`define SFSR_OP_SOFT_RESET    8'hf0
`define SFSR_OP_PROGRAM       8'h02
`define SFSR_OP_OTP_PROGRAM   8'h9b
`define SFSR_OP_ERASE_PAGE    8'h81
`define SFSR_OP_ERASE_4K      8'h20
`define SFSR_OP_ERASE_32K     8'h52
`define SFSR_OP_ERASE_32K_ALT 8'hd8
`define SFSR_OP_CHIP_ERASE    8'h60
`define SFSR_OP_CHIP_ERASE_B  8'hc7

// ==========================================================
// Field positions, byte one
`define SFSR_S1_LOCK 7
`define SFSR_S1_PERR 5
`define SFSR_S1_WPP  4
`define SFSR_S1_BP   2
`define SFSR_S1_WEL  1
`define SFSR_S1_BUSY 0
// Field positions, byte two
`define SFSR_S2_RESET_ENABLE 4
`define SFSR_S2_BUSY 0

// ==========================================================
// Reset values
`define SFSR_LOCK_RST 1'b0
`define SFSR_BP_RST   1'b0
`define SFSR_PERR_RST 1'b0
`define SFSR_WEL_RST  1'b0
`define SFSR_RESET_ENABLE_RST 1'b0
// Synchroniser reset: cs_n, sck, mosi, wp_n
`define SFSR_SYNC_RST 4'h9
// Bit count that closes a byte
`define SFSR_LAST_BIT 3'h7
// Byte count saturation: opcode plus one data byte
`define SFSR_BYTES_MAX 2'h2

`endif

// ===== design/sfsr_pkg.sv
// Types and helpers of the serial flash status register block
`include "sfsr_params.svh"
package sfsr_pkg;

  // ==========================================================
  // Pin group after synchronisation
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic mosi;
    logic wp_n;
  } sfsr_pins_t;

  // Request to the array engine
  typedef struct packed {
    logic       start;
    logic [7:0] code;
  } sfsr_op_t;

  // ==========================================================
  // Program or erase opcodes that touch the main array
  function automatic logic sfsr_is_array_op(input logic [7:0] op);
    sfsr_is_array_op = (op == `SFSR_OP_PROGRAM) ||
                       (op == `SFSR_OP_ERASE_PAGE) ||
                       (op == `SFSR_OP_ERASE_4K) ||
                       (op == `SFSR_OP_ERASE_32K) ||
                       (op == `SFSR_OP_ERASE_32K_ALT) ||
                       (op == `SFSR_OP_CHIP_ERASE) ||
                       (op == `SFSR_OP_CHIP_ERASE_B);
  endfunction

  // Any opcode that needs the write enable latch
  function automatic logic sfsr_is_write_op(input logic [7:0] op);
    sfsr_is_write_op = sfsr_is_array_op(op) ||
                       (op == `SFSR_OP_OTP_PROGRAM) ||
                       (op == `SFSR_OP_WRITE_STAT1) ||
                       (op == `SFSR_OP_WRITE_STAT2);
  endfunction

endpackage

// ===== design/sfsr_shifter.sv
// Status output shifter with output enable
`timescale 1ns/1ps
`default_nettype none
module sfsr_shifter
(
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_clear,
  input  wire logic       i_load,
  input  wire logic       i_shift,
  input  wire logic [7:0] i_byte,
  output var  logic       o_bit,
  output var  logic       o_oe
);

  logic [6:0] rest_reg;

  // ==========================================================
  // Load whole byte, then shift msb first
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rest_reg <= 7'h00;
      o_bit    <= 1'b0;
      o_oe     <= 1'b0;
    end
    else if (i_clear)
    begin
      o_oe <= 1'b0;
    end
    else if (i_load)
    begin
      o_bit    <= i_byte[7];
      rest_reg <= i_byte[6:0];
      o_oe     <= 1'b1;
    end
    else if (i_shift)
    begin
      o_bit    <= rest_reg[6];
      rest_reg <= {rest_reg[5:0], 1'b0};
    end
  end

endmodule
`default_nettype wire

// ===== design/sfsr_sync.sv
// Two-stage synchroniser for the pin group
`timescale 1ns/1ps
`default_nettype none
module sfsr_sync
  import sfsr_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  input  wire sfsr_pins_t i_pins,
  output var  sfsr_pins_t o_pins
);

  sfsr_pins_t meta_reg;

  // ==========================================================
  // Two flops per pin
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      meta_reg <= `SFSR_SYNC_RST;
      o_pins   <= `SFSR_SYNC_RST;
    end
    else
    begin
      meta_reg <= i_pins;
      o_pins   <= meta_reg;
    end
  end

endmodule
`default_nettype wire

// ===== design/sfsr_top.sv
// Status register bank and status read of a serial flash
// How it works
// R1: After select and opcode 05h, status bits leave on every clock.
// R2: Status reads are answered at any time, even while busy.
// R3: Byte one then two, msb first, repeating with fresh values.
// R4: Releasing select ends the read and floats the serial output.
// R5: Byte one: lock 7, error 5, pin 4, protect 2, latch 1, busy 0.
// R6: The byte-one write changes only bits 7 and 2.
// R7: Lock set with pin asserted freezes the protect bit.
// R8: Lock is 0 after power-up; then protect stays writable.
// R9: Pin asserted: lock may only rise; clearing needs the pin released.
// R10: Error flag set when the last program or erase failed.
// R11: Error flag untouched by aborted program or erase.
// R12: Error flag refreshed at the end of every program or erase.
// R13: Pin status reads 0 when pin asserted, 1 when released.
// R14: Protect 0 leaves array open; 1 rejects program and erase.
// R15: With latch clear, program, erase, OTP and status writes rejected.
// R16: Latch is 0 after power-up and after a reset.
// R17: Latch cleared on disable, finished or aborted writes.
// R18: Latch kept when the opcode was incomplete or unknown.
// R19: Busy reads 1 while working, in bit 0 of both bytes.
// R20: The host polls status until busy falls to 0.
// R21: Byte two: reset enable at 4, reserved 0, busy at 0.
// R22: Software reset ignored while reset enable is 0.
// R23: Reset enable changes only by the byte-two write.
// R24: Opcode 01h plus byte: bit 7 lock, bit 2 protect.
// R25: Opcode 31h plus byte: bit 4 reset enable, latch cleared.
// R26: Each status byte is sampled at its start.
`timescale 1ns/1ps
`default_nettype none
`include "sfsr_params.svh"
module sfsr_top
  import sfsr_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_spi_cs_n,
  input  wire logic       i_spi_sck,
  input  wire logic       i_spi_mosi,
  input  wire logic       i_wp_n,
  input  wire logic       i_op_busy,
  input  wire logic       i_op_done,
  input  wire logic       i_op_fail,
  output var  logic       o_spi_miso,
  output var  logic       o_spi_miso_oe,
  output var  logic       o_op_start,
  output var  logic [7:0] o_op_code,
  output var  logic       o_soft_reset,
  output var  logic       o_block_protect,
  output var  logic       o_write_enable_latch,
  output var  logic       o_reset_enable
);

  // ==========================================================
  // Pin synchronisation and edges
  sfsr_pins_t pins_s;
  logic       sck_prev_reg;
  logic       cs_prev_n_reg;

  sfsr_sync u_sync (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_pins    ({i_spi_cs_n, i_spi_sck, i_spi_mosi, i_wp_n}),
    .o_pins    (pins_s)
  );

  wire selected  = ~pins_s.cs_n;
  wire sck_rise  = selected & pins_s.sck & ~sck_prev_reg;
  wire sck_fall  = selected & ~pins_s.sck & sck_prev_reg;
  wire frame_end = pins_s.cs_n & ~cs_prev_n_reg;
  wire wp_on     = ~pins_s.wp_n;

  // ==========================================================
  // Frame receive state
  logic [2:0] bit_reg;
  logic [1:0] bytes_reg;
  logic [7:0] shin_reg;
  logic [7:0] opcode_reg;
  logic [7:0] data_reg;
  logic       sel_two_reg;

  wire [7:0] shin_next = {shin_reg[6:0], pins_s.mosi};
  wire       byte_done = sck_rise & (bit_reg == `SFSR_LAST_BIT);
  wire       full_op   = bytes_reg != 2'h0;
  wire       aligned   = bit_reg == 3'h0;
  wire       data_ok   = (bytes_reg == `SFSR_BYTES_MAX) & aligned;

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      sck_prev_reg  <= 1'b0;
      cs_prev_n_reg <= 1'b1;
      bit_reg       <= 3'h0;
      bytes_reg     <= 2'h0;
      shin_reg      <= 8'h00;
      opcode_reg    <= 8'h00;
      data_reg      <= 8'h00;
    end
    else
    begin
      sck_prev_reg  <= pins_s.sck;
      cs_prev_n_reg <= pins_s.cs_n;
      if (!selected)
      begin
        bit_reg   <= 3'h0;
        bytes_reg <= 2'h0;
      end
      else if (sck_rise)
      begin
        shin_reg <= shin_next;
        bit_reg  <= bit_reg + 3'h1;
        if (byte_done && bytes_reg == 2'h0)
          opcode_reg <= shin_next;
        if (byte_done && bytes_reg == 2'h1)
          data_reg <= shin_next;
        if (byte_done && bytes_reg != `SFSR_BYTES_MAX)
          bytes_reg <= bytes_reg + 2'h1;
      end
    end
  end

  // ==========================================================
  // Status bits
  logic lock_reg;
  logic bp_reg;
  logic perr_reg;
  logic wel_reg;
  logic reset_enable_reg;
  logic busy_reg;
  logic [7:0] stat_one;
  logic [7:0] stat_two;

  // R5: byte one layout, R13: pin status, R19: busy
  always_comb
  begin
    stat_one                 = 8'h00;
    stat_one[`SFSR_S1_LOCK]  = lock_reg;
    stat_one[`SFSR_S1_PERR]  = perr_reg;
    stat_one[`SFSR_S1_WPP]   = pins_s.wp_n;
    stat_one[`SFSR_S1_BP]    = bp_reg;
    stat_one[`SFSR_S1_WEL]   = wel_reg;
    stat_one[`SFSR_S1_BUSY]  = busy_reg;
    // R21: byte two layout, R19: busy
    stat_two                 = 8'h00;
    stat_two[`SFSR_S2_RESET_ENABLE]  = reset_enable_reg;
    stat_two[`SFSR_S2_BUSY]  = busy_reg;
  end

  // ==========================================================
  // Status read output
  // R1: read status after full opcode
  // R2: not gated by busy
  wire status_mode = full_op & (opcode_reg == `SFSR_OP_READ_STATUS);
  // R26: sample byte at its start
  wire st_load     = sck_fall & status_mode & aligned;
  wire st_shift    = sck_fall & status_mode & ~aligned;
  // R3: alternate byte one and two
  wire [7:0] st_byte = sel_two_reg ? stat_two : stat_one;

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      sel_two_reg <= 1'b0;
    else if (!selected)
      sel_two_reg <= 1'b0;
    else if (st_load)
      sel_two_reg <= ~sel_two_reg;
  end

  // R4: deselect floats output
  sfsr_shifter u_shifter (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_clear   (~selected),
    .i_load    (st_load),
    .i_shift   (st_shift),
    .i_byte    (st_byte),
    .o_bit     (o_spi_miso),
    .o_oe      (o_spi_miso_oe)
  );

  // ==========================================================
  // Command decode at frame end
  wire is_w1   = opcode_reg == `SFSR_OP_WRITE_STAT1;
  wire is_w2   = opcode_reg == `SFSR_OP_WRITE_STAT2;
  wire is_wr   = sfsr_is_write_op(opcode_reg);
  wire is_arr  = sfsr_is_array_op(opcode_reg);
  wire is_otp  = opcode_reg == `SFSR_OP_OTP_PROGRAM;
  wire cmd_end = frame_end & full_op & ~busy_reg;
  // R15: write-class needs latch
  wire wr_go   = cmd_end & is_wr & wel_reg;
  // R24: byte-one write fields
  wire new_lock = data_reg[`SFSR_S1_LOCK];
  wire new_bp   = data_reg[`SFSR_S1_BP];
  // R9: clearing lock needs pin released
  wire w1_bad   = wp_on & lock_reg & ~new_lock;
  wire w1_apply = wr_go & is_w1 & data_ok & ~w1_bad;
  // R7: lock with pin asserted freezes protect
  wire bp_frozen = lock_reg & wp_on;
  // R25: byte-two write
  wire w2_apply = wr_go & is_w2 & data_ok;
  // R14: protect rejects array ops
  wire op_go    = wr_go & aligned & ((is_arr & ~bp_reg) | is_otp);
  // R17: write-class end clears latch unless op started
  // R18: only after a full opcode
  wire wel_clr  = (cmd_end & is_wr & ~op_go) | i_op_done |
                  (cmd_end & opcode_reg == `SFSR_OP_WRITE_DISABLE);
  wire wel_set  = cmd_end & opcode_reg == `SFSR_OP_WRITE_ENABLE;
  // R22: software reset gated
  wire srst_go  = cmd_end & reset_enable_reg &
                  (opcode_reg == `SFSR_OP_SOFT_RESET);

  // ==========================================================
  // Status state
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      // R8: lock cleared at power-up
      lock_reg <= `SFSR_LOCK_RST;
      bp_reg   <= `SFSR_BP_RST;
      perr_reg <= `SFSR_PERR_RST;
      // R16: latch cleared at power-up
      wel_reg  <= `SFSR_WEL_RST;
      reset_enable_reg <= `SFSR_RESET_ENABLE_RST;
      busy_reg <= 1'b0;
    end
    else
    begin
      busy_reg <= i_op_busy;
      // R6: only lock and protect written
      if (w1_apply)
      begin
        lock_reg <= new_lock;
        if (!bp_frozen)
          bp_reg <= new_bp;
      end
      // R23: reset enable only by byte-two write
      if (w2_apply)
        reset_enable_reg <= data_reg[`SFSR_S2_RESET_ENABLE];
      // R12: refresh error on every end
      // R10: set on failure
      // R11: aborts never reach done
      if (i_op_done)
        perr_reg <= i_op_fail;
      // R16: software reset clears latch
      if (wel_clr || srst_go)
        wel_reg <= 1'b0;
      else if (wel_set)
        wel_reg <= 1'b1;
    end
  end

  // ==========================================================
  // Engine requests and mirrors
  sfsr_op_t op_reg;

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      op_reg       <= '0;
      o_soft_reset <= 1'b0;
    end
    else
    begin
      op_reg.start <= op_go;
      if (op_go)
        op_reg.code <= opcode_reg;
      o_soft_reset <= srst_go;
    end
  end

  assign o_op_start           = op_reg.start;
  assign o_op_code            = op_reg.code;
  assign o_block_protect      = bp_reg;
  assign o_write_enable_latch = wel_reg;
  assign o_reset_enable       = reset_enable_reg;

  // ==========================================================
  // Checks
  sequence s_frame_end;
    frame_end;
  endsequence

  sequence s_float;
    !o_spi_miso_oe [*2];
  endsequence

  property p_oe_status;
    @(posedge i_clk) disable iff (!i_reset_n)
    o_spi_miso_oe |-> opcode_reg == `SFSR_OP_READ_STATUS;
  endproperty
  a_oe_status: assert property (p_oe_status) // R1
    else $error("Output enabled outside status read");

  property p_float;
    @(posedge i_clk) disable iff (!i_reset_n)
    s_frame_end |=> s_float;
  endproperty
  a_float: assert property (p_float) // R4
    else $error("Output still driven after deselect");

  property p_first_bit;
    @(posedge i_clk) disable iff (!i_reset_n)
    $rose(o_spi_miso_oe) |-> o_spi_miso == $past(lock_reg);
  endproperty
  a_first_bit: assert property (p_first_bit) // R3
    else $error("First status bit is not the lock bit");

  property p_perr;
    @(posedge i_clk) disable iff (!i_reset_n)
    i_op_done |=> perr_reg == $past(i_op_fail);
  endproperty
  a_perr: assert property (p_perr) // R12
    else $error("Error flag not refreshed at operation end");

  property p_perr_hold;
    @(posedge i_clk) disable iff (!i_reset_n)
    !i_op_done |=> $stable(perr_reg);
  endproperty
  a_perr_hold: assert property (p_perr_hold) // R11
    else $error("Error flag changed without an operation end");

  property p_lock_clear;
    @(posedge i_clk) disable iff (!i_reset_n)
    $fell(lock_reg) |-> $past(pins_s.wp_n);
  endproperty
  a_lock_clear: assert property (p_lock_clear) // R9
    else $error("Lock cleared while pin asserted");

  property p_bp_frozen;
    @(posedge i_clk) disable iff (!i_reset_n)
    $changed(bp_reg) |-> !$past(bp_frozen);
  endproperty
  a_bp_frozen: assert property (p_bp_frozen) // R7
    else $error("Protect bit changed while locked");

  property p_start_gate;
    @(posedge i_clk) disable iff (!i_reset_n)
    o_op_start |-> $past(wel_reg) && (o_op_code == `SFSR_OP_OTP_PROGRAM
                   || !$past(bp_reg));
  endproperty
  a_start_gate: assert property (p_start_gate) // R15
    else $error("Operation started without latch or while protected");

  property p_reset_enable;
    @(posedge i_clk) disable iff (!i_reset_n)
    $changed(reset_enable_reg) |-> $past(frame_end) && $past(is_w2);
  endproperty
  a_reset_enable: assert property (p_reset_enable) // R23
    else $error("Reset enable changed outside its write");

  property p_srst;
    @(posedge i_clk) disable iff (!i_reset_n)
    o_soft_reset |-> $past(reset_enable_reg) ##1 !wel_reg;
  endproperty
  a_srst: assert property (p_srst) // R22
    else $error("Software reset honoured while disabled");

endmodule
`default_nettype wire

// ===== sim/sfsr_host_model.sv
// Behavioural SPI host that frames commands and collects status bytes
`timescale 1ns/1ps
`default_nettype none
module sfsr_host_model
(
  input  wire logic       i_clk,
  input  wire logic       i_spi_miso,
  output var  logic       o_spi_cs_n,
  output var  logic       o_spi_sck,
  output var  logic       o_spi_mosi,
  output var  logic       o_rx_valid,
  output var  logic [7:0] o_rx_byte
);
  logic idle;

  // ==========================================================
  // Idle state
  initial
  begin
    idle = 1'b1;
    o_spi_cs_n = 1'b1;
    o_spi_sck = 1'b0;
    o_spi_mosi = 1'b0;
    o_rx_valid = 1'b0;
    o_rx_byte = 8'h00;
  end

  // Released data line keeps changing between frames
  always @(negedge i_clk)
    if (idle)
      o_spi_mosi <= ~o_spi_mosi;

  // ==========================================================
  // One frame: tx bits msb first, then rx bits
  // select then opcode
  task automatic frame(input logic [15:0] tx, input int txb, input int rxb);
    logic [7:0] sh;
    sh = 8'h00;
    idle = 1'b0;
    @(negedge i_clk);
    o_spi_cs_n = 1'b0;
    for (int i = 0; i < txb + rxb; i++)
    begin
      repeat (4) @(negedge i_clk);
      o_spi_mosi = (i < txb) ? tx[15 - i] : ~o_spi_mosi;
      repeat (4) @(negedge i_clk);
      o_spi_sck = 1'b1;
      sh = {sh[6:0], i_spi_miso};
      repeat (8) @(negedge i_clk);
      o_spi_sck = 1'b0;
      if (i >= txb && (i - txb) % 8 == 7)
      begin
        o_rx_byte = sh;
        o_rx_valid = 1'b1;
        @(negedge i_clk);
        o_rx_valid = 1'b0;
      end
    end
    repeat (4) @(negedge i_clk);
    o_spi_cs_n = 1'b1;
    repeat (12) @(negedge i_clk);
    idle = 1'b1;
  endtask
endmodule
`default_nettype wire

// ===== sim/spi_flash_status_register_bench.sv
// Self-checking bench of the status register block
`timescale 1ns/1ps
`default_nettype none
module spi_flash_status_register_bench
  import sfsr_pkg::*;
;
  logic       clk, reset_n, wp_n, op_busy, op_done, op_fail;
  wire        cs_n, sck, mosi, miso, miso_oe, miso_w, rx_valid;
  wire        op_start, soft_reset, bp_out, wel_out, reset_enable_out;
  wire  [7:0] op_code, rx_byte;
  logic       lock, bp, perr, write_enable_latch, reset_enable, busy;
  logic [7:0] q_rx[$];
  logic [7:0] q_ev[$];
  logic [7:0] d;
  logic [7:0] ops[8];
  int         err_count, tests_run, seed;

  assign miso_w = miso_oe ? miso : 1'bz;

  sfsr_top dut (.i_clk(clk), .i_reset_n(reset_n), .i_spi_cs_n(cs_n),
    .i_spi_sck(sck), .i_spi_mosi(mosi), .i_wp_n(wp_n),
    .i_op_busy(op_busy), .i_op_done(op_done), .i_op_fail(op_fail),
    .o_spi_miso(miso), .o_spi_miso_oe(miso_oe), .o_op_start(op_start),
    .o_op_code(op_code), .o_soft_reset(soft_reset),
    .o_block_protect(bp_out), .o_write_enable_latch(wel_out),
    .o_reset_enable(reset_enable_out));

  sfsr_host_model host (.i_clk(clk), .i_spi_miso(miso_w),
    .o_spi_cs_n(cs_n), .o_spi_sck(sck), .o_spi_mosi(mosi),
    .o_rx_valid(rx_valid), .o_rx_byte(rx_byte));

  // ==========================================================
  // Helpers
  function automatic logic [7:0] s1();
    return {lock, 1'b0, perr, wp_n, 1'b0, bp, write_enable_latch, busy};
  endfunction

  function automatic logic [7:0] s2();
    return {3'h0, reset_enable, 3'h0, busy};
  endfunction

  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic report_and_stop();
    if (err_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic read_st(int n, int extra);
    for (int i = 0; i < n; i++)
      q_rx.push_back(i[0] ? s2() : s1());
    host.frame({8'h05, 8'h00}, 8, n * 8 + extra);
  endtask

  task automatic cmd(logic [7:0] op, logic [7:0] dat, int bits);
    host.frame({op, dat}, bits, 0);
  endtask

  task automatic wren();
    cmd(8'h06, 8'h00, 8);
    write_enable_latch = 1'b1;
  endtask

  task automatic levels();
    chk("levels", {5'h0, bp, write_enable_latch, reset_enable}, {5'h0, bp_out, wel_out, reset_enable_out});
  endtask

  task automatic wait_ev();
    for (int i = 0; i < 40 && q_ev.size() != 0; i++)
      @(negedge clk);
    if (q_ev.size() != 0)
    begin
      err_count++;
      $display("mismatch op_event expected 0 seen %0d", q_ev.size());
      report_and_stop();
    end
  endtask

  // ==========================================================
  // Result watcher
  always @(posedge clk)
  begin
    if (rx_valid === 1'b1)
      chk("status", q_rx.size() ? q_rx.pop_front() : 8'hxx, rx_byte);
  end

  // Engine events launch on the rising edge, so look half a cycle later
  always @(negedge clk)
  begin
    if (op_start === 1'b1)
      chk("op_code", q_ev.size() ? q_ev.pop_front() : 8'hxx, op_code);
    if (soft_reset === 1'b1)
      chk("soft_reset", q_ev.size() ? q_ev.pop_front() : 8'hxx, 8'hf0);
  end

  // ==========================================================
  // Clock and watchdog
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial
  begin
    repeat (100000) @(posedge clk);
    err_count++;
    $display("mismatch watchdog expected 0 seen 1");
    report_and_stop();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    err_count = 0;
    tests_run = 0;
    seed = 32'h02449d21;
    ops = '{8'h02, 8'h81, 8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7, 8'h9b};
    {reset_n, op_busy, op_done, op_fail} = 4'h0;
    {lock, bp, perr, write_enable_latch, reset_enable, busy} = 6'h00;
    wp_n = 1'b1;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    levels();
    read_st(4, 0);
    read_st(1, 3);
    chk("miso_oe", 8'h00, {7'h0, miso_oe});
    cmd(8'h01, 8'h84, 16);
    levels();
    wren();
    cmd(8'h04, 8'h00, 8);
    write_enable_latch = 1'b0;
    levels();
    wren();
    cmd(8'h01, 8'h00, 5);
    cmd(8'h3c, 8'h00, 8);
    levels();
    d = $random(seed);
    d[7] = 1'b0;
    d[2] = 1'b1;
    cmd(8'h01, d, 16);
    bp = 1'b1;
    write_enable_latch = 1'b0;
    read_st(2, 0);
    wren();
    cmd(8'h01, 8'h00, 8);
    write_enable_latch = 1'b0;
    levels();
    wren();
    cmd(8'h02, 8'h00, 16);
    write_enable_latch = 1'b0;
    read_st(2, 0);
    wren();
    cmd(8'h01, 8'h00, 16);
    {bp, write_enable_latch} = 2'b00;
    for (int i = 0; i < 8; i++)
    begin
      wren();
      q_ev.push_back(ops[i]);
      cmd(ops[i], 8'($random(seed)), 16);
      wait_ev();
      op_busy = 1'b1;
      busy = 1'b1;
      repeat (2) @(negedge clk);
      read_st(2, 0);
      op_fail = i[0];
      op_done = 1'b1;
      @(negedge clk);
      {op_done, op_busy} = 2'b00;
      {perr, write_enable_latch, busy} = {i[0], 2'b00};
      repeat (3) @(negedge clk);
      read_st(2, 0);
    end
    wp_n = 1'b0;
    wren();
    cmd(8'h01, 8'h84, 16);
    {lock, bp, write_enable_latch} = 3'b110;
    read_st(2, 0);
    wren();
    cmd(8'h01, 8'h80, 16);
    write_enable_latch = 1'b0;
    levels();
    wren();
    cmd(8'h01, 8'h00, 16);
    write_enable_latch = 1'b0;
    read_st(1, 0);
    wp_n = 1'b1;
    wren();
    cmd(8'h01, 8'h00, 16);
    {lock, bp, write_enable_latch} = 3'b000;
    read_st(1, 0);
    cmd(8'hf0, 8'h00, 8);
    wait_ev();
    wren();
    cmd(8'h31, 8'h10 | 8'($random(seed)), 16);
    {reset_enable, write_enable_latch} = 2'b10;
    levels();
    q_ev.push_back(8'hf0);
    cmd(8'hf0, 8'h00, 8);
    wait_ev();
    levels();
    read_st(2, 0);
    chk("left", 8'h00, 8'(q_rx.size() + q_ev.size()));
    report_and_stop();
  end
endmodule
`default_nettype wire
